// >>> dv/pdmux_asserts.sv
/* pdmux_asserts.sv: port-level checks for the upper pin mux.
   assumes: bound into pdmux_top; address and data arrive together. */
`timescale 1ns/100ps
module pdmux_asserts #(
    parameter LARGE_PACKAGE = 1,
    parameter NBITS = 3
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // register writes
    input logic [11:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic s_axi_wvalid,
    // pins
    input logic [NBITS-1:0] portPinIn,
    input logic [NBITS-1:0] portPinOut,
    input logic [NBITS-1:0] portPinOe,
    // memory and host port engines
    input logic [NBITS-1:0] memAddrDataOut,
    input logic memDriveEn,
    input logic memReadPhase,
    input logic [NBITS-1:0] memReadData,
    input logic hostRead,
    input logic hostWrite,
    input logic [NBITS-1:0] hostWriteData,
    input logic hostWriteStrobe,
    // serial module
    input logic serSpiMode,
    input logic serI2cMode,
    input logic serSpiMaster,
    input logic serI2cDataOe,
    input logic serSpiClockOut,
    input logic serDataIn
);
    logic [7:0] ctl_ff, dir_ff, lat_ff, pendData_ff;
    logic [11:0] pendAddr_ff;
    logic pend_ff;
    wire memOwn = (LARGE_PACKAGE != 0) && !ctl_ff[7];
    wire hostOn = ctl_ff[4];
    // register mirror, applied one edge after the take as the slave does;
    // only valid while both halves are offered together
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= 8'h80;
            dir_ff <= 8'hff;
            lat_ff <= 8'h00;
            pend_ff <= 1'b0;
            pendAddr_ff <= 12'h000;
            pendData_ff <= 8'h00;
        end else begin
            pend_ff <= s_axi_awvalid && s_axi_awready && s_axi_wvalid;
            pendAddr_ff <= s_axi_awaddr;
            pendData_ff <= s_axi_wdata[7:0];
            if (pend_ff) begin
                if (pendAddr_ff == 12'h000 || pendAddr_ff == 12'h004)
                    lat_ff <= pendData_ff;
                if (pendAddr_ff == 12'h008)
                    dir_ff <= pendData_ff;
                if (pendAddr_ff == 12'h00c)
                    ctl_ff <= pendData_ff;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_mem_drive:
        assert property (memOwn |-> portPinOe == {NBITS{memDriveEn}}
            && (!memDriveEn || portPinOut == memAddrDataOut))
        else $error("memory drive wrong");
    chk_mem_capture:
        assert property (memOwn && memReadPhase |=>
            memReadData == $past(portPinIn)) else $error("memory capture");
    chk_host_read:
        assert property (!memOwn && hostOn && hostRead |->
            portPinOe[2] && portPinOut[2] == lat_ff[7]) else $error("host read");
    chk_host_write:
        assert property (!memOwn && hostOn && $rose(hostWrite) |=>
            hostWriteStrobe && hostWriteData == $past(portPinIn))
        else $error("host write");
    chk_plain_drive:
        assert property (!memOwn && !hostOn && !serSpiMode && !serI2cMode |->
            portPinOe == ~dir_ff[7:5]
            && ((portPinOut ^ lat_ff[7:5]) & portPinOe) == 3'h0)
        else $error("plain drive");
    chk_i2c_data:
        assert property (!memOwn && serI2cMode && serI2cDataOe && dir_ff[5]
            |-> portPinOe[0] && !portPinOut[0]) else $error("i2c data");
    chk_spi_clock:
        assert property (!memOwn && serSpiMode && serSpiMaster && !dir_ff[6]
            |-> portPinOe[1] && portPinOut[1] == serSpiClockOut)
        else $error("spi clock");
    chk_spi_data:
        assert property (serSpiMode && dir_ff[5] |=>
            serDataIn == $past(portPinIn[0])) else $error("spi data in");
endmodule

bind pdmux_top pdmux_asserts #(.LARGE_PACKAGE(LARGE_PACKAGE),
    .NBITS(NBITS)) u_chk (.*);

// >>> dv/pdmux_partner.sv
/* pdmux_partner.sv: far-side peer on pins 5..7.
   assumes: the bench decides which pins the peer drives. */
`timescale 1ns/100ps
module pdmux_partner (
    // clock for the float pattern
    input logic clk,
    // device side of the pins
    input logic [2:0] pinOut,
    input logic [2:0] pinOe,
    // peer drive
    input logic [2:0] extVal,
    input logic [2:0] extOe,
    // wire level seen by the device
    output logic [2:0] pinIn
);
    logic [2:0] floatLvl_ff = 3'h5;
    // no pull on these lines, so an undriven pin wanders every cycle
    always @(posedge clk) begin
        floatLvl_ff <= ~floatLvl_ff;
    end
    // device drive first, then the peer, else the wandering level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
        | (~pinOe & ~extOe & floatLvl_ff);
endmodule

// >>> dv/tb_port_d_upper_pin_mux.sv
/* tb_port_d_upper_pin_mux.sv: register and pin tests for the mux.
   assumes: pdmux_top, its checker and the pin peer are compiled first. */
`timescale 1ns/100ps
module tb_port_d_upper_pin_mux;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, hostWriteStrobe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] portPinIn, portPinOut, portPinOe, memReadData, hostWriteData;
    logic [2:0] memAddrDataOut = '0, extVal = '0, extOe = '0;
    logic memDriveEn = 0, memReadPhase = 0, hostRead = 0, hostWrite = 0;
    logic serSpiMode = 0, serI2cMode = 0, serSpiMaster = 0, serI2cDataOe = 0;
    logic serI2cClockOe = 0, serSpiClockOut = 0;
    logic serDataIn, serClockIn, serSlaveSelectIn;
    int errors = 0, totalChecks = 0;
    pdmux_top dut (.*);
    pdmux_partner peer (.clk, .pinOut(portPinOut), .pinOe(portPinOe),
        .extVal, .extOe, .pinIn(portPinIn));
    logic [2:0] smallOe, smallOut;
    // small build on the same stimulus: no memory bus at all
    pdmux_top #(.LARGE_PACKAGE(0)) dutSmall (.clk, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
        .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
        .portPinIn, .portPinOut(smallOut), .portPinOe(smallOe),
        .memAddrDataOut, .memDriveEn, .memReadPhase, .memReadData(),
        .hostRead, .hostWrite, .hostWriteData(), .hostWriteStrobe(),
        .serSpiMode, .serI2cMode, .serSpiMaster, .serI2cDataOe,
        .serI2cClockOe, .serSpiClockOut, .serDataIn(), .serClockIn(),
        .serSlaveSelectIn());
    // 100 ns clock
    always #50 clk = ~clk;
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wrap_up;
        if (errors == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic [4:0] s;
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // ready is sampled mid-cycle; inputs only move at rising edges
        do begin
            @(negedge clk);
            s = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
                s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
            if (s[4]) s_axi_awvalid <= 1'b0;
            if (s[3]) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s[2] && n < 50);
        s_axi_bready <= 1'b0;
        check("bvalid", 32'h1, 32'(s[2]));
        check("bresp", 32'(r), 32'(s[1:0]));
    endtask
    task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic [35:0] s;
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            s = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rresp,
                s_axi_rdata};
            @(posedge clk);
            if (s[35]) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s[34] && n < 50);
        s_axi_rready <= 1'b0;
        check("rvalid", 32'h1, 32'(s[34]));
        check("rresp", 32'(r), 32'(s[33:32]));
        check("rdata", d, s[31:0]);
    endtask
    // peer drive, then one edge so captures land
    task drv(input logic [2:0] oe, input logic [2:0] v);
        @(posedge clk);
        extOe <= oe;
        extVal <= v;
        @(posedge clk);
    endtask
    task pins(input logic [2:0] oe, input logic [2:0] o);
        @(negedge clk);
        check("portPinOe", 32'(oe), 32'(portPinOe));
        check("portPinOut", 32'(o), 32'(portPinOut & portPinOe));
        @(posedge clk);
    endtask
    // hang guard, far past the fewer than a hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h004, 32'h00, 2'h0);
        rd(12'h008, 32'hff, 2'h0);
        rd(12'h00c, 32'h80, 2'h0);
        rd(12'h020, 32'h00, 2'h2);
        wr(12'h020, 32'hff, 2'h2);
        wr(12'h008, 32'h1f, 2'h0);
        wr(12'h004, 32'ha0, 2'h0);
        pins(3'h7, 3'h5);
        wr(12'h008, 32'h5f, 2'h0);
        drv(3'h2, 3'h2);
        pins(3'h5, 3'h5);
        rd(12'h000, 32'he0, 2'h0);
        wr(12'h008, 32'hff, 2'h0);
        wr(12'h00c, 32'h90, 2'h0);
        rd(12'h010, 32'h2, 2'h0);
        hostRead <= 1'b1;
        extOe <= '0;
        pins(3'h7, 3'h5);
        hostRead <= 1'b0;
        pins(3'h0, 3'h0);
        drv(3'h7, 3'h6);
        hostWrite <= 1'b1;
        @(posedge clk);
        hostWrite <= 1'b0;
        @(negedge clk);
        check("hostWriteStrobe", 32'h1, 32'(hostWriteStrobe));
        check("hostWriteData", 32'h6, 32'(hostWriteData));
        @(posedge clk);
        hostRead <= 1'b1;
        extOe <= '0;
        serI2cMode <= 1'b1;
        serI2cDataOe <= 1'b1;
        pins(3'h7, 3'h4);
        hostRead <= 1'b0;
        serI2cDataOe <= 1'b0;
        // i2c then spi slave: pins routed to the serial inputs
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            serI2cMode <= (k < 2);
            serSpiMode <= (k > 1);
            extOe <= 3'h7;
            extVal <= k[0] ? 3'h5 : 3'h2;
            @(posedge clk);
            @(negedge clk);
            check("serClockIn", 32'(!k[0]), 32'(serClockIn));
            if (k > 1) begin
                check("serDataIn", 32'(k[0]), 32'(serDataIn));
                check("slaveSel", 32'(k[0]), 32'(serSlaveSelectIn));
            end
        end
        wr(12'h008, 32'hbf, 2'h0);
        serSpiMaster <= 1'b1;
        serSpiClockOut <= 1'b1;
        extOe <= 3'h5;
        pins(3'h2, 3'h2);
        serSpiMode <= 1'b0;
        serI2cMode <= 1'b1;
        serI2cClockOe <= 1'b1;
        pins(3'h2, 3'h0);
        wr(12'h00c, 32'h10, 2'h0);
        hostRead <= 1'b1;
        serI2cDataOe <= 1'b1;
        memDriveEn <= 1'b1;
        memAddrDataOut <= 3'h3;
        extOe <= '0;
        @(negedge clk);
        check("smallOe", 32'h7, 32'(smallOe));
        check("smallOut", 32'h4, 32'(smallOut & smallOe));
        pins(3'h7, 3'h3);
        memDriveEn <= 1'b0;
        memReadPhase <= 1'b1;
        pins(3'h0, 3'h0);
        drv(3'h7, 3'h6);
        @(negedge clk);
        check("memReadData", 32'h6, 32'(memReadData));
        rd(12'h010, 32'h5, 2'h0);
        wr(12'h00c, 32'h80, 2'h0);
        extOe <= '0;
        memReadPhase <= 1'b0;
        pins(3'h3, 3'h0);
        wrap_up;
    end
endmodule

// >>> src/pdmux_defines.vh
/*
 pdmux_defines.vh: register offsets, field positions and reset values for
 the upper port pin multiplexer.
 assumes: included by bare name from the design files.
*/
`ifndef PDMUX_DEFINES_VH
`define PDMUX_DEFINES_VH

// register byte offsets on the register bus
`define PDMUX_OFF_PIN_LEVEL 12'h000
`define PDMUX_OFF_OUT_LATCH 12'h004
`define PDMUX_OFF_DIRECTION 12'h008
`define PDMUX_OFF_CONTROL 12'h00c
`define PDMUX_OFF_STATUS 12'h010

// control register fields
`define PDMUX_CTL_MEM_DISABLE 7
`define PDMUX_CTL_HOST_MODE 4

// reset values: pins come up as inputs, memory bus disabled
`define PDMUX_RST_LATCH 8'h00
`define PDMUX_RST_DIR 8'hff
`define PDMUX_RST_CONTROL 8'h80

// status register field positions
`define PDMUX_ST_MEM_OWN 0
`define PDMUX_ST_HOST_OWN 1
`define PDMUX_ST_SER_OWN 2

// axi response codes
`define PDMUX_RESP_OKAY 2'b00
`define PDMUX_RESP_SLVERR 2'b10

`endif

// >>> src/pdmux_pin_cell.v
/*
 pdmux_pin_cell.v: one pin's output priority resolver.
 assumes: all selects are synchronous levels from the parent mux.
*/
`timescale 1ns/100ps

module pdmux_pin_cell (
    // memory interface
    input wire memOwn,
    input wire memOe,
    input wire memOut,
    // serial module
    input wire serOwn,
    input wire serOe,
    input wire serOut,
    // host parallel port
    input wire hostOwn,
    input wire hostOe,
    input wire hostOut,
    // plain port
    input wire dirBit,
    input wire latchBit,
    // resolved pin drive
    output reg pinOe,
    output reg pinOut
);

    // fixed priority: memory, serial, host port, plain latch
    always @* begin
        if (memOwn) begin
            pinOe = memOe; // RULE_17
            pinOut = memOut;
        end else if (serOwn) begin
            pinOe = serOe; // RULE_17
            pinOut = serOut;
        end else if (hostOwn) begin
            pinOe = hostOe; // RULE_17
            pinOut = hostOut;
        end else begin
            pinOe = ~dirBit; // RULE_01
            pinOut = latchBit; // RULE_02
        end
    end

endmodule

// >>> src/pdmux_top.v
/*
 pdmux_top.v: pin function multiplexer for port bits 5..7 with an
 axi4-lite register slave holding latch, direction and control.
 assumes: one clock, pins and peripheral signals synchronous to clk,
 the memory, host-port and serial engines live outside this block.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pdmux_defines.vh"

// How it works
// [RULE_01] direction 0 drives a pin from its latch bit when nothing outranks it.
// [RULE_02] direction 1 floats the pin and reads it as an input.
// [RULE_03] the memory bus owns the pins only while its disable bit is clear.
// [RULE_04] host-mode bit gives the pins to the host port, below memory.
// [RULE_05] memory drives bits 5 and 6 over host port, serial and latch.
// [RULE_06] memory drives bit 7 over host port and latch.
// [RULE_07] memory read phases capture bits 5..7 regardless of direction.
// [RULE_08] host read presents latch bits on the pins, ignoring direction.
// [RULE_09] host write takes the pin byte as write data, ignoring direction.
// [RULE_10] spi with direction 5 at 1 routes pin 5 to serial data in.
// [RULE_11] i2c lets the serial module drive pin 5 data, over host and latch.
// [RULE_12] spi master drives clock on pin 6 at direction 0, reads at 1.
// [RULE_13] i2c drives clock on pin 6 at direction 0, samples at 1.
// [RULE_14] spi slave with direction 7 at 1 takes slave select from pin 7.
// [RULE_15] memory and host port functions ignore the direction bits.
// [RULE_16] memory functions exist only when the large-package build is set.
// [RULE_17] pin drive resolves memory, serial, host port, then latch.
module pdmux_top #(
    parameter LARGE_PACKAGE = 1,
    parameter NBITS = 3
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins 5..7
    input wire [NBITS-1:0] portPinIn,
    output wire [NBITS-1:0] portPinOut,
    output wire [NBITS-1:0] portPinOe,
    // external memory engine
    input wire [NBITS-1:0] memAddrDataOut,
    input wire memDriveEn,
    input wire memReadPhase,
    output reg [NBITS-1:0] memReadData,
    // host parallel port engine
    input wire hostRead,
    input wire hostWrite,
    output reg [NBITS-1:0] hostWriteData,
    output reg hostWriteStrobe,
    // second serial module
    input wire serSpiMode,
    input wire serI2cMode,
    input wire serSpiMaster,
    input wire serI2cDataOe,
    input wire serI2cClockOe,
    input wire serSpiClockOut,
    output reg serDataIn,
    output reg serClockIn,
    output reg serSlaveSelectIn
);

    // registers
    reg [7:0] latch_ff;
    reg [7:0] dir_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] pinLevel_ff;
    reg [11:0] awAddr_ff;
    reg awHave_ff;
    reg [31:0] wData_ff;
    reg [3:0] wStrb_ff;
    reg wHave_ff;

    // ownership decode
    wire memOwn;
    wire hostOwn;
    wire [NBITS-1:0] dirHi;
    wire [NBITS-1:0] latHi;
    wire [NBITS-1:0] serOwn;
    wire [NBITS-1:0] serOe;
    wire [NBITS-1:0] serOut;
    wire doWrite;
    wire [7:0] pinFull;

    // word-aligned byte decode shared by read and write paths
    function [2:0] regSel;
        input [11:0] addr;
        begin
            case (addr)
                `PDMUX_OFF_PIN_LEVEL: regSel = 3'h1;
                `PDMUX_OFF_OUT_LATCH: regSel = 3'h2;
                `PDMUX_OFF_DIRECTION: regSel = 3'h3;
                `PDMUX_OFF_CONTROL: regSel = 3'h4;
                `PDMUX_OFF_STATUS: regSel = 3'h5;
                default: regSel = 3'h0;
            endcase
        end
    endfunction

    // byte-lane merge of a write into an 8-bit register
    function [7:0] laneMerge;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            laneMerge = strb[0] ? data[7:0] : old;
        end
    endfunction

    // memory bus absent in small build; disable bit releases pins
    assign memOwn = (LARGE_PACKAGE != 0) &&
        !ctrl_ff[`PDMUX_CTL_MEM_DISABLE]; // RULE_03 RULE_16
    assign hostOwn = !memOwn && ctrl_ff[`PDMUX_CTL_HOST_MODE]; // RULE_04
    assign dirHi = dir_ff[7:5];
    assign latHi = latch_ff[7:5];

    // serial claims: pin5 i2c data, pin6 clock when direction is 0
    assign serOwn[0] = serI2cMode; // RULE_11
    assign serOe[0] = serI2cDataOe; // open drain low drive
    assign serOut[0] = 1'b0;
    assign serOwn[1] = (serI2cMode || (serSpiMode && serSpiMaster)) &&
        !dirHi[1]; // RULE_12 RULE_13
    assign serOe[1] = serI2cMode ? serI2cClockOe : 1'b1;
    assign serOut[1] = serI2cMode ? 1'b0 : serSpiClockOut;
    // pin7 is only an input to the serial module
    assign serOwn[2] = 1'b0;
    assign serOe[2] = 1'b0;
    assign serOut[2] = 1'b0;

    // one resolver per pin; bit 7 gets no serial override
    genvar g;
    generate
        for (g = 0; g < NBITS; g = g + 1) begin : gPin
            pdmux_pin_cell uCell (
                .memOwn(memOwn), // RULE_05 RULE_06
                .memOe(memDriveEn), // RULE_15
                .memOut(memAddrDataOut[g]),
                .serOwn(serOwn[g]),
                .serOe(serOe[g]),
                .serOut(serOut[g]),
                .hostOwn(hostOwn),
                .hostOe(hostRead), // RULE_08 RULE_15
                .hostOut(latHi[g]),
                .dirBit(dirHi[g]),
                .latchBit(latHi[g]),
                .pinOe(portPinOe[g]),
                .pinOut(portPinOut[g])
            );
        end
    endgenerate

    // input routing registered; data outputs come from flip-flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memReadData <= {NBITS{1'b0}};
            hostWriteData <= {NBITS{1'b0}};
            hostWriteStrobe <= 1'b0;
            serDataIn <= 1'b0;
            serClockIn <= 1'b0;
            serSlaveSelectIn <= 1'b1;
            pinLevel_ff <= 8'h00;
        end else begin
            pinLevel_ff <= {portPinIn, 5'h00};
            if (memOwn && memReadPhase)
                memReadData <= portPinIn; // RULE_07
            hostWriteStrobe <= hostOwn && hostWrite;
            if (hostOwn && hostWrite)
                hostWriteData <= portPinIn; // RULE_09
            if ((serSpiMode && dirHi[0]) || serI2cMode)
                serDataIn <= portPinIn[0]; // RULE_10
            if (dirHi[1] && (serSpiMode || serI2cMode))
                serClockIn <= portPinIn[1]; // RULE_12 RULE_13
            if (serSpiMode && !serSpiMaster && dirHi[2])
                serSlaveSelectIn <= portPinIn[2]; // RULE_14
        end
    end

    // axi write: address and data taken in either order
    assign s_axi_awready = !awHave_ff && !s_axi_bvalid;
    assign s_axi_wready = !wHave_ff && !s_axi_bvalid;
    assign doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awAddr_ff <= 12'h000;
            awHave_ff <= 1'b0;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
            wHave_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDMUX_RESP_OKAY;
            latch_ff <= `PDMUX_RST_LATCH;
            dir_ff <= `PDMUX_RST_DIR;
            ctrl_ff <= `PDMUX_RST_CONTROL;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_ff <= s_axi_awaddr;
                awHave_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wHave_ff <= 1'b1;
            end
            if (doWrite) begin
                awHave_ff <= 1'b0;
                wHave_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PDMUX_RESP_OKAY;
                case (regSel(awAddr_ff))
                    // pin-level writes land in the latch, as on a port
                    3'h1: latch_ff <= laneMerge(latch_ff, wData_ff, wStrb_ff);
                    3'h2: latch_ff <= laneMerge(latch_ff, wData_ff, wStrb_ff);
                    3'h3: dir_ff <= laneMerge(dir_ff, wData_ff, wStrb_ff);
                    3'h4: ctrl_ff <= laneMerge(ctrl_ff, wData_ff, wStrb_ff)
                        & 8'h90;
                    3'h5: s_axi_bresp <= `PDMUX_RESP_OKAY; // status is ro
                    default: s_axi_bresp <= `PDMUX_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read: one-cycle answer, held until rready
    assign s_axi_arready = !s_axi_rvalid;
    assign pinFull = pinLevel_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PDMUX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PDMUX_RESP_OKAY;
            case (regSel(s_axi_araddr))
                3'h1: s_axi_rdata <= {24'h000000, pinFull};
                3'h2: s_axi_rdata <= {24'h000000, latch_ff};
                3'h3: s_axi_rdata <= {24'h000000, dir_ff};
                3'h4: s_axi_rdata <= {24'h000000, ctrl_ff};
                3'h5: s_axi_rdata <= {29'h00000000, |serOwn, hostOwn,
                    memOwn};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PDMUX_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
